// ### hw/dmr_alu_map.vh
// constants for the multiply-accumulate, max, merge and move datapath
`ifndef DMR_ALU_MAP_VH
`define DMR_ALU_MAP_VH
// operation codes from decode
`define DMR_OP_NOP 3'h0
`define DMR_OP_RMAC 3'h1
`define DMR_OP_RMACI 3'h2
`define DMR_OP_MAX 3'h3
`define DMR_OP_MAXMAG 3'h4
`define DMR_OP_MERGE 3'h5
`define DMR_OP_MOVE 3'h6
// low byte of the instruction word for the one-word forms
`define DMR_OPC_MAX 8'h1D
`define DMR_OPC_MAXMAG 8'h15
`define DMR_OPC_MOVE 8'h00
`define DMR_OPC_HI 7
`define DMR_MOVE_HI 23
`define DMR_MOVE_LO 8
// condition code bit positions
`define DMR_CC_C 0
`define DMR_CC_V 1
`define DMR_CC_Z 2
`define DMR_CC_N 3
`define DMR_CC_U 4
`define DMR_CC_E 5
`define DMR_CC_L 6
`define DMR_CC_S 7
`define DMR_CC_RESET 8'h00
// accumulator fields
`define DMR_ACC_HI_MSB 47
`define DMR_ACC_HI_LSB 24
`define DMR_ACC_LO_MSB 23
`define DMR_ACC_RESET 56'h00000000000000
// round point weight
`define DMR_RND_HALF 56'h00000000800000
`define DMR_LOW_MASK 56'hFFFFFFFF000000
`define DMR_LOW_HALF 24'h800000
`endif

// ### hw/dmr_mul.v
// signed multiplier with sign select, product as a fraction in 56 bits
`timescale 1ns/1ns
module dmr_mul #(
    parameter W = 24,
    parameter AW = 56
) (
    // operands
    input wire [W-1:0] mul_a,
    input wire [W-1:0] mul_b,
    input wire negate,
    // product
    output wire [AW-1:0] prod
);
    wire signed [2*W-1:0] raw;
    wire signed [AW-1:0] ext;
    assign raw = $signed(mul_a) * $signed(mul_b);
    // fractional multiply: one left shift drops the duplicate sign bit
    assign ext = {{(AW-2*W){raw[2*W-1]}}, raw[2*W-2:0], 1'b0};
    assign prod = negate ? (~ext + {{(AW-1){1'b0}}, 1'b1}) : ext; // RULE4
endmodule

// ### hw/dmr_flags.v
// standard flag terms for a 56-bit accumulator result
`timescale 1ns/1ns
`include "dmr_alu_map.vh"
module dmr_flags #(
    parameter AW = 56
) (
    // value
    input wire [AW-1:0] val,
    // flags
    output wire ext_used,
    output wire unnorm,
    output wire neg,
    output wire zero,
    output wire scale
);
    // extension in use when bits 55..47 are not all equal
    assign ext_used = ~(&val[AW-1:`DMR_ACC_HI_MSB] |
        ~|val[AW-1:`DMR_ACC_HI_MSB]);
    assign unnorm = ~(val[`DMR_ACC_HI_MSB] ^ val[`DMR_ACC_HI_MSB-1]);
    assign neg = val[AW-1];
    assign zero = ~|val;
    // scaling: bits 46 and 45 differ marks growth past half scale
    assign scale = val[`DMR_ACC_HI_MSB-1] ^ val[`DMR_ACC_HI_MSB-2];
endmodule

// ### hw/dmr_alu.v
// datapath unit: round mac, max transfers, half-word merge, plain move
//
// Operation
// RULE1: after rounding, clear accumulator low word for an unbiased value
// RULE2: register mac-round updates S L E U N Z V, keeps carry
// RULE3: immediate mac-round multiplies signed 24-bit values, 56-bit sum
// RULE4: minus sign negates the product first; plus is default
// RULE5: immediate multiplier comes from the extension word after the opcode
// RULE6: two-bit field picks source register, one bit picks accumulator
// RULE7: rounded result stays in the accumulator upper portion
// RULE8: signed max copies source when destination minus source not positive
// RULE9: magnitude max compares absolute values the same way
// RULE10: max ops clear carry on transfer, else set; update S and L only
// RULE11: max and move are one word, move field 23..8, opcode 7..0
// RULE12: merge places src 11..0 above dst 35..24 into bits 47..24
// RULE13: sixteen-bit mode merges src 15..8 with dst 39..32 into 47..32
// RULE14: merge sets N from bit 47, Z from 47..24, clears V
// RULE15: move does no arithmetic, updates only S and L
// RULE16: arithmetic runs alongside up to two parallel bus moves
// RULE17: rounding kind is an outside setting sampled at execution
`timescale 1ns/1ns
`include "dmr_alu_map.vh"
module dmr_alu #(
    parameter W = 24,
    parameter AW = 56
) (
    // clock and reset
    input wire core_clk,
    input wire rstn,
    // instruction from decode
    input wire exec,
    input wire [2:0] op,
    input wire [W-1:0] iword,
    input wire [W-1:0] ext_word,
    input wire [1:0] source_register_select,
    input wire dst_sel,
    input wire negate,
    input wire [2:0] src2_sel,
    input wire [2:0] merge_src_sel,
    // mode settings
    input wire rnd_twos,
    input wire sixteen_mode,
    input wire scale_dn,
    input wire scale_up,
    // input registers x0 x1 y0 y1
    input wire [W-1:0] x0,
    input wire [W-1:0] x1,
    input wire [W-1:0] y0,
    input wire [W-1:0] y1,
    // parallel bus writes to accumulators
    input wire bus_wr_a,
    input wire bus_wr_b,
    input wire [AW-1:0] bus_wdata,
    // state
    output reg [AW-1:0] acc_a_q,
    output reg [AW-1:0] acc_b_q,
    output reg [7:0] condition_code_register,
    output reg [W-1:0] move_field_q,
    output reg busy_q
);
    ////////////////////////////////////////////////////////////////////
    // operand selection
    function [W-1:0] pick4;
        input [1:0] s;
        input [W-1:0] r0;
        input [W-1:0] r1;
        input [W-1:0] r2;
        input [W-1:0] r3;
        begin
            case (s)
                2'h0: pick4 = r0;
                2'h1: pick4 = r1;
                2'h2: pick4 = r2;
                default: pick4 = r3;
            endcase
        end
    endfunction

    function [AW-1:0] absv;
        input [AW-1:0] v;
        begin
            absv = v[AW-1] ? (~v + {{(AW-1){1'b0}}, 1'b1}) : v;
        end
    endfunction

    wire [AW-1:0] dst_acc;
    wire [AW-1:0] src_acc;
    wire [W-1:0] s_reg;
    wire [W-1:0] m_a;
    wire [W-1:0] m_b;
    wire [W-1:0] merge_src;
    wire [AW-1:0] prod;
    assign dst_acc = dst_sel ? acc_b_q : acc_a_q; // RULE6
    assign src_acc = dst_sel ? acc_a_q : acc_b_q;
    // x0 y0 x1 y1 order for the immediate form
    assign s_reg = pick4(source_register_select, x0, y0, x1, y1); // RULE6
    // immediate takes the extension word, register form a second reg
    assign m_a = (op == `DMR_OP_RMACI) ? ext_word : // RULE5
        pick4(src2_sel[1:0], x0, y0, x1, y1);
    assign m_b = s_reg;
    assign merge_src = merge_src_sel[2] ?
        (merge_src_sel[0] ? acc_b_q[`DMR_ACC_HI_MSB:`DMR_ACC_HI_LSB] :
        acc_a_q[`DMR_ACC_HI_MSB:`DMR_ACC_HI_LSB]) :
        pick4(merge_src_sel[1:0], x0, x1, y0, y1);

    dmr_mul #(.W(W), .AW(AW)) u_mul (
        .mul_a(m_a),
        .mul_b(m_b),
        .negate(negate),
        .prod(prod)
    ); // RULE3

    ////////////////////////////////////////////////////////////////////
    // accumulate and round
    wire [AW-1:0] sum;
    wire [AW:0] sum_wide;
    wire sum_ovf;
    wire [AW-1:0] rnd_pre;
    wire tie;
    wire [AW-1:0] rnd_res;
    assign sum_wide = {dst_acc[AW-1], dst_acc} + {prod[AW-1], prod};
    assign sum = sum_wide[AW-1:0];
    assign sum_ovf = sum_wide[AW] ^ sum_wide[AW-1];
    assign rnd_pre = sum + `DMR_RND_HALF;
    // convergent: exact half rounds to even by clearing bit 24
    assign tie = (sum[`DMR_ACC_LO_MSB:0] == `DMR_LOW_HALF);
    assign rnd_res = (rnd_pre & `DMR_LOW_MASK) & // RULE1 RULE7
        ~({{(AW-1){1'b0}}, (tie & ~rnd_twos)} << `DMR_ACC_HI_LSB); // RULE17

    ////////////////////////////////////////////////////////////////////
    // max compares
    wire [AW:0] sdiff;
    wire [AW:0] mdiff;
    wire take_s;
    wire take_m;
    assign sdiff = {dst_acc[AW-1], dst_acc} - {src_acc[AW-1], src_acc};
    assign mdiff = {1'b0, absv(dst_acc)} - {1'b0, absv(src_acc)};
    assign take_s = sdiff[AW] | ~|sdiff; // RULE8
    assign take_m = mdiff[AW] | ~|mdiff; // RULE9

    ////////////////////////////////////////////////////////////////////
    // merge
    wire [AW-1:0] merged;
    assign merged = sixteen_mode ?
        {dst_acc[AW-1:`DMR_ACC_HI_MSB+1], merge_src[15:8],
        dst_acc[39:32], dst_acc[31:0]} : // RULE13
        {dst_acc[AW-1:`DMR_ACC_HI_MSB+1], merge_src[11:0],
        dst_acc[35:24], dst_acc[23:0]}; // RULE12

    ////////////////////////////////////////////////////////////////////
    // flag terms
    wire f_e;
    wire f_u;
    wire f_n;
    wire f_z;
    wire f_s;
    wire mv_s;
    dmr_flags #(.AW(AW)) u_flags (
        .val(rnd_res),
        .ext_used(f_e),
        .unnorm(f_u),
        .neg(f_n),
        .zero(f_z),
        .scale(f_s)
    );
    // scaling and limit for ops that only move data
    assign mv_s = (scale_dn | scale_up) ?
        (dst_acc[`DMR_ACC_HI_MSB] ^ dst_acc[`DMR_ACC_HI_MSB-1]) :
        (dst_acc[`DMR_ACC_HI_MSB-1] ^ dst_acc[`DMR_ACC_HI_MSB-2]);
    wire mv_l;
    assign mv_l = ~(&dst_acc[AW-1:`DMR_ACC_HI_MSB] |
        ~|dst_acc[AW-1:`DMR_ACC_HI_MSB]);

    ////////////////////////////////////////////////////////////////////
    // register update
    reg [AW-1:0] res_d;
    reg wr_d;
    reg [7:0] cc_d;
    always @*
    begin
        res_d = dst_acc;
        wr_d = 1'b0;
        cc_d = condition_code_register;
        if (exec)
        begin
            case (op)
                `DMR_OP_RMAC, `DMR_OP_RMACI:
                begin
                    res_d = rnd_res; // RULE1 RULE3 RULE7
                    wr_d = 1'b1;
                    cc_d[`DMR_CC_S] = condition_code_register[`DMR_CC_S]
                        | f_s; // RULE2
                    cc_d[`DMR_CC_L] = condition_code_register[`DMR_CC_L]
                        | sum_ovf;
                    cc_d[`DMR_CC_E] = f_e;
                    cc_d[`DMR_CC_U] = f_u;
                    cc_d[`DMR_CC_N] = f_n;
                    cc_d[`DMR_CC_Z] = f_z;
                    cc_d[`DMR_CC_V] = sum_ovf; // RULE2
                end
                `DMR_OP_MAX, `DMR_OP_MAXMAG:
                begin
                    if ((op == `DMR_OP_MAX) ? take_s : take_m)
                    begin
                        res_d = src_acc; // RULE8 RULE9
                        wr_d = 1'b1;
                    end
                    cc_d[`DMR_CC_C] = ~((op == `DMR_OP_MAX) ?
                        take_s : take_m); // RULE10
                    cc_d[`DMR_CC_S] = condition_code_register[`DMR_CC_S]
                        | mv_s; // RULE10
                    cc_d[`DMR_CC_L] = condition_code_register[`DMR_CC_L]
                        | mv_l;
                end
                `DMR_OP_MERGE:
                begin
                    res_d = merged;
                    wr_d = 1'b1;
                    cc_d[`DMR_CC_N] = merged[`DMR_ACC_HI_MSB]; // RULE14
                    cc_d[`DMR_CC_Z] = ~|merged[`DMR_ACC_HI_MSB:
                        `DMR_ACC_HI_LSB]; // RULE14
                    cc_d[`DMR_CC_V] = 1'b0; // RULE14
                end
                `DMR_OP_MOVE:
                begin
                    // no arithmetic, accumulator kept
                    cc_d[`DMR_CC_S] = condition_code_register[`DMR_CC_S]
                        | mv_s; // RULE15
                    cc_d[`DMR_CC_L] = condition_code_register[`DMR_CC_L]
                        | mv_l; // RULE15
                end
                default:
                begin
                    cc_d = condition_code_register;
                end
            endcase
        end
    end

    // the alu result wins over a bus write to the same accumulator;
    // software must not name both, so this only defines the hazard
    always @(posedge core_clk)
    begin
        if (!rstn)
        begin
            acc_a_q <= `DMR_ACC_RESET;
            acc_b_q <= `DMR_ACC_RESET;
            condition_code_register <= `DMR_CC_RESET;
            move_field_q <= {W{1'b0}};
            busy_q <= 1'b0;
        end
        else
        begin
            condition_code_register <= cc_d;
            busy_q <= exec;
            // bus move field registered, seen one cycle after exec
            if (exec)
                move_field_q <= {iword[`DMR_MOVE_HI:`DMR_MOVE_LO],
                    iword[`DMR_OPC_HI:0]}; // RULE11 RULE16
            if (wr_d && !dst_sel)
                acc_a_q <= res_d;
            else if (bus_wr_a)
                acc_a_q <= bus_wdata; // RULE16
            if (wr_d && dst_sel)
                acc_b_q <= res_d;
            else if (bus_wr_b)
                acc_b_q <= bus_wdata; // RULE16
        end
    end
endmodule

// ### bench/dmr_alu_checker.sv
// checker for the round mac, max, merge and move datapath
`timescale 1ns/1ns
`include "dmr_alu_map.vh"
module dmr_alu_checker (
    // clock, reset, instruction
    input wire core_clk,
    input wire rstn,
    input wire exec,
    input wire [2:0] op,
    input wire [23:0] iword,
    input wire dst_sel,
    input wire sixteen_mode,
    input wire bus_wr_a,
    input wire bus_wr_b,
    // state
    input wire [55:0] acc_a_q,
    input wire [55:0] acc_b_q,
    input wire [7:0] condition_code_register,
    input wire [23:0] move_field_q
);
default clocking cb @(posedge core_clk); endclocking
default disable iff (!rstn);
////////////////////////////////////////////////////////////////////////////
wire [7:0] cc = condition_code_register;
wire go = exec && rstn;
wire quiet = !bus_wr_a && !bus_wr_b;
wire ismax = go && quiet && (op == `DMR_OP_MAX || op == `DMR_OP_MAXMAG);
wire [55:0] dst = dst_sel ? acc_b_q : acc_a_q;
wire [55:0] src = dst_sel ? acc_a_q : acc_b_q;
// destination as seen one cycle after the instruction
reg ds_q;
wire [55:0] pd = ds_q ? acc_b_q : acc_a_q;
always @(posedge core_clk) ds_q <= dst_sel;
// 57 bits so that the most negative value still has a magnitude
function automatic [56:0] mag(input [55:0] v);
    mag = v[55] ? (57'h0 - {1'b1, v}) : {1'b0, v};
endfunction
////////////////////////////////////////////////////////////////////////////
property p_low_clr;
    go && (op == `DMR_OP_RMAC || op == `DMR_OP_RMACI) |=> pd[23:0] == 24'h0;
endproperty
a_low_clr: assert property (p_low_clr)
    else $error("low word not cleared after rounding");
property p_keep_c;
    go && op == `DMR_OP_RMAC |=> cc[0] == $past(cc[0]);
endproperty
a_keep_c: assert property (p_keep_c)
    else $error("carry changed by register mac round");
property p_max_c;
    ismax |=> cc[`DMR_CC_C] == (pd != $past(src));
endproperty
a_max_c: assert property (p_max_c)
    else $error("carry does not mirror the transfer");
property p_max_kept;
    ismax |=> cc[5:1] == $past(cc[5:1]);
endproperty
a_max_kept: assert property (p_max_kept)
    else $error("max changed E U N Z V");
property p_smax;
    ismax && op == `DMR_OP_MAX && $signed(dst) <= $signed(src)
        |=> pd == $past(src);
endproperty
a_smax: assert property (p_smax)
    else $error("signed max did not transfer");
property p_mmax;
    ismax && op == `DMR_OP_MAXMAG && mag(dst) <= mag(src)
        |=> pd == $past(src);
endproperty
a_mmax: assert property (p_mmax)
    else $error("magnitude max did not transfer");
property p_merge_cc;
    go && op == `DMR_OP_MERGE |=> cc[3] == pd[47] && !cc[1]
        && cc[2] == (pd[47:24] == 24'h0) && cc[7:4] == $past(cc[7:4]);
endproperty
a_merge_cc: assert property (p_merge_cc)
    else $error("merge flags wrong");
property p_merge_keep;
    go && quiet && op == `DMR_OP_MERGE && !sixteen_mode
        |=> pd[55:48] == $past(dst[55:48]) && pd[35:0] == $past(dst[35:0]);
endproperty
a_merge_keep: assert property (p_merge_keep)
    else $error("merge touched bits outside its field");
property p_merge16;
    go && quiet && op == `DMR_OP_MERGE && sixteen_mode
        |=> pd[55:48] == $past(dst[55:48]) && pd[39:0] == $past(dst[39:0]);
endproperty
a_merge16: assert property (p_merge16)
    else $error("sixteen-bit merge touched other bits");
property p_move;
    go && op == `DMR_OP_MOVE |=> cc[5:0] == $past(cc[5:0]);
endproperty
a_move: assert property (p_move)
    else $error("move changed flags other than S and L");
property p_field;
    go |=> move_field_q == $past(iword);
endproperty
a_field: assert property (p_field)
    else $error("move field not captured");
c_rmaci: cover property (go && op == `DMR_OP_RMACI);
c_max: cover property (ismax);
c_merge: cover property (go && op == `DMR_OP_MERGE && sixteen_mode);
endmodule
bind dmr_alu dmr_alu_checker chk (.core_clk(core_clk), .rstn(rstn),
    .exec(exec), .op(op), .iword(iword), .dst_sel(dst_sel),
    .sixteen_mode(sixteen_mode), .bus_wr_a(bus_wr_a), .bus_wr_b(bus_wr_b),
    .acc_a_q(acc_a_q), .acc_b_q(acc_b_q), .move_field_q(move_field_q),
    .condition_code_register(condition_code_register));

// ### bench/tb.sv
// scenario testbench for the datapath unit
`timescale 1ns/1ns
`include "dmr_alu_map.vh"
`define CHK(n, e, g) begin checks = checks + 1; if ((g) !== (e)) begin \
    failures = failures + 1; \
    $display("ERROR %s expected %h seen %h", n, e, g); end end
module tb;
logic core_clk, rstn, exec, dst_sel, negate, rnd_twos, sixteen_mode;
logic bus_wr_a, bus_wr_b;
logic [2:0] op, src2_sel, merge_src_sel;
logic [1:0] source_register_select;
logic [23:0] iword, ext_word, x0, x1, y0, y1;
logic [55:0] bus_wdata;
wire [55:0] a, b;
wire [7:0] cc;
wire [23:0] mf;
wire bz;
int checks, failures, i;
dmr_alu uut (.core_clk(core_clk), .rstn(rstn), .exec(exec), .op(op),
    .iword(iword), .ext_word(ext_word), .dst_sel(dst_sel), .negate(negate),
    .source_register_select(source_register_select), .src2_sel(src2_sel),
    .merge_src_sel(merge_src_sel), .rnd_twos(rnd_twos), .scale_dn(1'b0),
    .sixteen_mode(sixteen_mode), .scale_up(1'b0), .x0(x0), .x1(x1),
    .y0(y0), .y1(y1), .bus_wr_a(bus_wr_a), .bus_wr_b(bus_wr_b),
    .bus_wdata(bus_wdata), .acc_a_q(a), .acc_b_q(b),
    .condition_code_register(cc), .move_field_q(mf), .busy_q(bz));
////////////////////////////////////////////////////////////////////////////
task report_and_stop;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0)
        $display("ALL CHECKS OK");
    else
        $display("CHECKS NOT OK");
    $finish;
endtask
task ex(input [2:0] o);
    @(posedge core_clk) #1 exec = 1; op = o;
    @(posedge core_clk) #1 exec = 0;
endtask
// accumulators are loaded through the parallel bus path
task ld(input [55:0] va, input [55:0] vb);
    @(posedge core_clk) #1 bus_wr_a = 1; bus_wdata = va;
    @(posedge core_clk) #1 bus_wr_a = 0; bus_wr_b = 1; bus_wdata = vb;
    @(posedge core_clk) #1 bus_wr_b = 0;
endtask
task t_round;
    x0 = 24'h400001; ext_word = 24'h400000; ld(0, 0); ex(`DMR_OP_RMACI);
    `CHK("conv", 56'h00200000000000, a)
    rnd_twos = 1; ld(0, 0); ex(`DMR_OP_RMACI);
    `CHK("twos", 56'h00200001000000, a)
    negate = 1; dst_sel = 1; ld(0, 0); ex(`DMR_OP_RMACI);
    `CHK("neg", 56'hFFE00000000000, b)
    negate = 0; ex(`DMR_OP_RMACI);
    `CHK("acc", 56'h00000001000000, b)
    dst_sel = 0;
    for (i = 0; i < 4; i++)
    begin
        x0 = (i == 0) ? 24'h400000 : 0; y0 = (i == 1) ? 24'h400000 : 0;
        x1 = (i == 2) ? 24'h400000 : 0; y1 = (i == 3) ? 24'h400000 : 0;
        source_register_select = i; ld(0, 0); ex(`DMR_OP_RMACI);
        `CHK("sel", 56'h00200000000000, a)
    end
endtask
task t_max(input [2:0] o, input [55:0] d, s, ea, input ec);
    iword = {16'hA5C3, (o == `DMR_OP_MAX) ? `DMR_OPC_MAX : `DMR_OPC_MAXMAG};
    ld(d, s); ex(o);
    `CHK("max acc", ea, a)
    `CHK("max carry", ec, cc[`DMR_CC_C])
    `CHK("max field", iword, mf)
endtask
task t_mac_with_rounding;
    x0 = 24'h400000; y0 = 24'h400000; source_register_select = 0;
    src2_sel = 3'h1; ld(0, 0); ex(`DMR_OP_RMAC);
    `CHK("mac_with_rounding", 56'h00200000000000, a)
    `CHK("mac_with_rounding cc", 4'h1, {cc[3:2], cc[1:0]})
endtask
task t_merge(input [55:0] d, input [23:0] s, input m, input [55:0] e,
    input [2:0] f);
    x0 = s; sixteen_mode = m; merge_src_sel = 0; ld(d, 0); ex(`DMR_OP_MERGE);
    `CHK("merge", e, a)
    `CHK("merge nzv", f, cc[3:1])
    sixteen_mode = 0;
endtask
task t_move;
    logic [7:0] old;
    iword = {16'hBEEF, `DMR_OPC_MOVE}; ld(56'h00123456000000, 0); old = cc;
    @(posedge core_clk) #1 exec = 1; op = `DMR_OP_MOVE;
    bus_wr_b = 1; bus_wdata = 56'h00777777000000;
    @(posedge core_clk) #1 exec = 0; bus_wr_b = 0;
    `CHK("move b", 56'h00777777000000, b)
    `CHK("move a", 56'h00123456000000, a)
    `CHK("move cc", old[5:0], cc[5:0])
    `CHK("move field", 24'hBEEF00, mf)
    `CHK("busy", 1'b1, bz)
    ex(`DMR_OP_NOP);
    `CHK("nop a", 56'h00123456000000, a)
    `CHK("nop cc", old, cc)
endtask
initial
begin
    core_clk = 0;
    forever #5 core_clk = ~core_clk;
end
initial
begin
    #20000;
    failures = failures + 1;
    report_and_stop;
end
initial
begin
    {exec, dst_sel, negate, rnd_twos, sixteen_mode, bus_wr_a, bus_wr_b} = 0;
    {op, src2_sel, merge_src_sel, source_register_select} = 0;
    {iword, ext_word, x0, x1, y0, y1, bus_wdata} = 0;
    checks = 0; failures = 0; rstn = 0;
    repeat (6) @(posedge core_clk);
    #1 rstn = 1;
    `CHK("reset", 64'h0, {a, cc})
    t_round;
    t_max(`DMR_OP_MAX, 5, 3, 5, 1);
    t_max(`DMR_OP_MAX, 3, 5, 5, 0);
    t_max(`DMR_OP_MAX, -1, -1, -1, 0);
    t_max(`DMR_OP_MAXMAG, -2, -5, -5, 0);
    t_max(`DMR_OP_MAXMAG, -8, 5, -8, 1);
    t_mac_with_rounding;
    t_merge(56'h123456789ABCDE, 24'h000ABC, 0, 56'h12ABC6789ABCDE, 3'h4);
    t_merge(56'h123456789ABCDE, 24'h00CD00, 1, 56'h12CD56789ABCDE, 3'h4);
    t_merge(0, 0, 0, 0, 3'h2);
    t_move;
    report_and_stop;
end
endmodule
